// ===== cmdsa_core.v
// Character-mode destination string datapath with entry sequencer.
// Assumes core memory on the same clock answering each access with
// a one-cycle acknowledge; software drives the plain register port.
`timescale 1ns/1ps
`include "cmdsa_regs.vh"
module cmdsa_core #(
    parameter AW = 15
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire [4:0] i_addr,
    input wire [47:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [47:0] o_rdata,
    output reg [AW-1:0] o_mem_addr,
    output reg [47:0] o_mem_wdata,
    output reg o_mem_wr,
    output reg o_mem_rd,
    input wire [47:0] i_mem_rdata,
    input wire i_mem_ack,
    output reg o_char_mode_flag,
    output reg o_subprogram_level_flag
);
// ==========================================================
// States
localparam ST_IDLE = 4'b0001;
localparam ST_ALIGN = 4'b0010;
localparam ST_MEMW = 4'b0100;
localparam ST_MEMR = 4'b1000;

// ==========================================================
// Datapath registers
reg [3:0] state;
reg [4:0] op;
reg [47:0] dest_word;
reg [AW-1:0] dest_addr;
reg [AW-1:0] saved_addr;
reg [3:0] shift_cnt;
reg [2:0] char_sel;
reg [2:0] bit_sel;
reg [5:0] work_char;
reg [5:0] src_char;
reg [11:0] syllable;
reg [AW-1:0] ret_ptr;
reg [38:0] loop_ctrl;
reg [AW-1:0] prog_addr;
reg [AW-1:0] src_addr;
reg [5:0] tally;
reg [47:0] prog_desc;
reg stack_mark_flag;
reg rejected;

wire busy = (state != ST_IDLE);
wire cmd_go = i_wr && (i_addr == `CMDSA_R_CMD) && !busy;
wire reg_wr = i_wr && !busy;
wire [AW-1:0] ptr_minus = ret_ptr - {{(AW-6){1'b0}}, syllable[11:6]};
wire [AW-1:0] dest_inc = dest_addr + {{(AW-1){1'b0}}, 1'b1};
wire aligned = (shift_cnt[3:1] == char_sel) && !shift_cnt[0];
wire desc_marked = prog_desc[`CMDSA_DESC_MODE] &&
                   prog_desc[`CMDSA_DESC_ARG];

// ==========================================================
// Bit select decode: character bit 0 is the most significant
function [5:0] bmask;
    input [2:0] sel;
    begin
        bmask = 6'h20 >> sel;
    end
endfunction

// ==========================================================
// Register read data, one cycle after the strobe
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        o_rdata <= 48'h000000000000;
    end else if (i_rd) begin
        case (i_addr)
            `CMDSA_R_WORD: o_rdata <= dest_word;
            `CMDSA_R_DADDR: o_rdata <= {{(48-AW){1'b0}}, dest_addr};
            `CMDSA_R_SCNT: o_rdata <= {44'h0, shift_cnt};
            `CMDSA_R_CSEL: o_rdata <= {45'h0, char_sel};
            `CMDSA_R_BSEL: o_rdata <= {45'h0, bit_sel};
            `CMDSA_R_WCHR: o_rdata <= {42'h0, work_char};
            `CMDSA_R_SCHR: o_rdata <= {42'h0, src_char};
            `CMDSA_R_SYL: o_rdata <= {36'h0, syllable};
            `CMDSA_R_RPTR: o_rdata <= {{(48-AW){1'b0}}, ret_ptr};
            `CMDSA_R_LOOP: o_rdata <= {9'h0, loop_ctrl};
            `CMDSA_R_PADDR: o_rdata <= {{(48-AW){1'b0}}, prog_addr};
            `CMDSA_R_SADDR: o_rdata <= {{(48-AW){1'b0}}, src_addr};
            `CMDSA_R_FLAGS: o_rdata <= {43'h0, rejected, busy,
                stack_mark_flag, o_subprogram_level_flag,
                o_char_mode_flag};
            `CMDSA_R_TALLY: o_rdata <= {42'h0, tally};
            `CMDSA_R_DESC: o_rdata <= prog_desc;
            default: o_rdata <= 48'h000000000000;
        endcase
    end else begin
        o_rdata <= 48'h000000000000;
    end
end

// ==========================================================
// Command sequencer and datapath
always @(posedge i_clk) begin
    if (i_sys_rst) begin
        state <= ST_IDLE;
        op <= 5'h00;
        dest_word <= 48'h000000000000;
        dest_addr <= `CMDSA_RST_ADDR;
        saved_addr <= `CMDSA_RST_ADDR;
        shift_cnt <= `CMDSA_RST_SCNT;
        char_sel <= 3'h0;
        bit_sel <= 3'h0;
        work_char <= 6'h00;
        src_char <= 6'h00;
        syllable <= 12'h000;
        ret_ptr <= `CMDSA_RST_ADDR;
        loop_ctrl <= 39'h0000000000;
        prog_addr <= `CMDSA_RST_ADDR;
        src_addr <= `CMDSA_RST_ADDR;
        tally <= 6'h00;
        prog_desc <= 48'h000000000000;
        stack_mark_flag <= 1'b0;
        rejected <= 1'b0;
        o_char_mode_flag <= 1'b0;
        o_subprogram_level_flag <= 1'b0;
        o_mem_addr <= `CMDSA_RST_ADDR;
        o_mem_wdata <= 48'h000000000000;
        o_mem_wr <= 1'b0;
        o_mem_rd <= 1'b0;
    end else begin
        o_mem_wr <= 1'b0;
        o_mem_rd <= 1'b0;
        case (state)
            ST_IDLE: begin
                // Software register writes, taken only while idle
                if (reg_wr) begin
                    case (i_addr)
                        `CMDSA_R_WORD: dest_word <= i_wdata;
                        `CMDSA_R_DADDR: dest_addr <= i_wdata[AW-1:0];
                        `CMDSA_R_SCNT: shift_cnt <= i_wdata[3:0];
                        `CMDSA_R_CSEL: char_sel <= i_wdata[2:0];
                        `CMDSA_R_BSEL: bit_sel <= i_wdata[2:0];
                        `CMDSA_R_WCHR: work_char <= i_wdata[5:0];
                        `CMDSA_R_SCHR: src_char <= i_wdata[5:0];
                        `CMDSA_R_SYL: syllable <= i_wdata[11:0];
                        `CMDSA_R_RPTR: ret_ptr <= i_wdata[AW-1:0];
                        `CMDSA_R_LOOP: loop_ctrl <= i_wdata[38:0];
                        `CMDSA_R_PADDR: prog_addr <= i_wdata[AW-1:0];
                        `CMDSA_R_SADDR: src_addr <= i_wdata[AW-1:0];
                        `CMDSA_R_FLAGS: begin
                            stack_mark_flag <= i_wdata[`CMDSA_F_MARK];
                            o_char_mode_flag <= i_wdata[`CMDSA_F_CM];
                            o_subprogram_level_flag <=
                                i_wdata[`CMDSA_F_SP];
                            rejected <= 1'b0;
                        end
                        `CMDSA_R_TALLY: tally <= i_wdata[5:0];
                        `CMDSA_R_DESC: prog_desc <= i_wdata;
                        default: ;
                    endcase
                end
                if (cmd_go) begin
                    op <= i_wdata[4:0];
                    case (i_wdata[4:0])
                        `CMDSA_C_SHL: begin
                            // Circular left octade rotate
                            dest_word <= {dest_word[44:0],
                                          dest_word[47:45]};
                            shift_cnt <= shift_cnt + 4'h1;
                        end
                        `CMDSA_C_SHR: begin
                            // Circular right octade rotate
                            dest_word <= {dest_word[2:0],
                                          dest_word[47:3]};
                            shift_cnt <= shift_cnt - 4'h1;
                        end
                        `CMDSA_C_ALIGN: state <= ST_ALIGN;
                        `CMDSA_C_FETCH:
                            work_char <= dest_word[47:42];
                        `CMDSA_C_PUT:
                            dest_word[5:0] <= work_char;
                        `CMDSA_C_ADD:
                            work_char <= work_char + src_char;
                        `CMDSA_C_BLOAD:
                            work_char <= (work_char & ~bmask(bit_sel)) |
                                (src_char & bmask(bit_sel));
                        `CMDSA_C_BSET:
                            work_char <= work_char | bmask(bit_sel);
                        `CMDSA_C_BCLR:
                            work_char <= work_char &
                                ~bmask(bit_sel);
                        `CMDSA_C_YTOB:
                            dest_word[5:0] <= src_char;
                        `CMDSA_C_LIT:
                            work_char <= syllable[11:6];
                        `CMDSA_C_SYLB: begin
                            // Syllable character via source char
                            src_char <= syllable[11:6];
                            dest_word[5:0] <= syllable[11:6];
                        end
                        `CMDSA_C_NEXT: begin
                            // Store finished word back
                            o_mem_addr <= dest_addr;
                            o_mem_wdata <= dest_word;
                            o_mem_wr <= 1'b1;
                            state <= ST_MEMW;
                        end
                        `CMDSA_C_LCW: begin
                            // Borrow the destination address
                            saved_addr <= dest_addr;
                            dest_addr <= loop_ctrl[29:15] + 15'h0001;
                            o_mem_addr <= loop_ctrl[29:15] + 15'h0001;
                            o_mem_wdata <= `CMDSA_CW_FLAGS |
                                {10'h000, loop_ctrl[37:0]};
                            o_mem_wr <= 1'b1;
                            state <= ST_MEMW;
                        end
                        `CMDSA_C_FDA: begin
                            dest_addr <= ptr_minus;
                            o_mem_addr <= ptr_minus;
                            o_mem_rd <= 1'b1;
                            state <= ST_MEMR;
                        end
                        `CMDSA_C_FSA: begin
                            src_addr <= ptr_minus;
                            o_mem_addr <= ptr_minus;
                            o_mem_rd <= 1'b1;
                            state <= ST_MEMR;
                        end
                        `CMDSA_C_ENTD, `CMDSA_C_ENTI: begin
                            if ((i_wdata[4:0] == `CMDSA_C_ENTI) ||
                                (desc_marked && stack_mark_flag)) begin
                                if (i_wdata[4:0] == `CMDSA_C_ENTD)
                                    prog_addr <= prog_desc[14:0];
                                // Push return word above last entry
                                dest_addr <= dest_inc;
                                ret_ptr <= dest_inc;
                                loop_ctrl <= 39'h0000000000;
                                o_mem_addr <= dest_inc;
                                o_mem_wdata <= `CMDSA_CW_FLAGS |
                                    {18'h00000, ret_ptr,
                                     15'h0000};
                                o_mem_wr <= 1'b1;
                                state <= ST_MEMW;
                            end else begin
                                // Unmarked descriptor or no stack mark
                                rejected <= 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_ALIGN: begin
                // Rotate left until the selected character sits out
                if (aligned) begin
                    state <= ST_IDLE;
                end else begin
                    dest_word <= {dest_word[44:0],
                                  dest_word[47:45]};
                    shift_cnt <= shift_cnt + 4'h1;
                end
            end
            ST_MEMW: begin
                if (i_mem_ack) begin
                    case (op)
                        `CMDSA_C_NEXT: begin
                            // Step address and read next word
                            dest_addr <= dest_inc;
                            o_mem_addr <= dest_inc;
                            o_mem_rd <= 1'b1;
                            state <= ST_MEMR;
                        end
                        `CMDSA_C_LCW: begin
                            dest_addr <= saved_addr;
                            state <= ST_IDLE;
                        end
                        default: begin
                            // Entry completes
                            loop_ctrl <= {9'h000, dest_addr,
                                          15'h0000};
                            tally <= 6'h00;
                            dest_addr <= `CMDSA_RST_ADDR;
                            o_char_mode_flag <= 1'b1;
                            o_subprogram_level_flag <= 1'b1;
                            stack_mark_flag <= 1'b0;
                            state <= ST_IDLE;
                        end
                    endcase
                end
            end
            ST_MEMR: begin
                if (i_mem_ack) begin
                    case (op)
                        `CMDSA_C_NEXT: begin
                            dest_word <= i_mem_rdata;
                            shift_cnt <= `CMDSA_RST_SCNT;
                        end
                        `CMDSA_C_FDA:
                            dest_addr <= i_mem_rdata[14:0];
                        default:
                            src_addr <= i_mem_rdata[14:0];
                    endcase
                    state <= ST_IDLE;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

endmodule // cmdsa_core

// ===== cmdsa_regs.vh
// Constants for the character-mode destination string datapath.
// Assumes a single 100 MHz clock and a word-wide core memory port.
`ifndef CMDSA_REGS_VH
`define CMDSA_REGS_VH
// Register offsets (word index on the plain register port)
`define CMDSA_R_CMD 5'h00
`define CMDSA_R_WORD 5'h01
`define CMDSA_R_DADDR 5'h02
`define CMDSA_R_SCNT 5'h03
`define CMDSA_R_CSEL 5'h04
`define CMDSA_R_BSEL 5'h05
`define CMDSA_R_WCHR 5'h06
`define CMDSA_R_SCHR 5'h07
`define CMDSA_R_SYL 5'h08
`define CMDSA_R_RPTR 5'h09
`define CMDSA_R_LOOP 5'h0a
`define CMDSA_R_PADDR 5'h0b
`define CMDSA_R_SADDR 5'h0c
`define CMDSA_R_FLAGS 5'h0d
`define CMDSA_R_TALLY 5'h0e
`define CMDSA_R_DESC 5'h0f
// Command codes written to the command register
`define CMDSA_C_SHL 5'h01
`define CMDSA_C_SHR 5'h02
`define CMDSA_C_ALIGN 5'h03
`define CMDSA_C_FETCH 5'h04
`define CMDSA_C_PUT 5'h05
`define CMDSA_C_ADD 5'h06
`define CMDSA_C_BLOAD 5'h07
`define CMDSA_C_BSET 5'h08
`define CMDSA_C_BCLR 5'h09
`define CMDSA_C_YTOB 5'h0a
`define CMDSA_C_LIT 5'h0b
`define CMDSA_C_SYLB 5'h0c
`define CMDSA_C_NEXT 5'h0d
`define CMDSA_C_LCW 5'h0e
`define CMDSA_C_FDA 5'h0f
`define CMDSA_C_FSA 5'h10
`define CMDSA_C_ENTD 5'h11
`define CMDSA_C_ENTI 5'h12
// Field positions
`define CMDSA_DESC_MODE 43
`define CMDSA_DESC_ARG 42
`define CMDSA_F_CM 0
`define CMDSA_F_SP 1
`define CMDSA_F_MARK 2
`define CMDSA_F_BUSY 3
`define CMDSA_F_REJ 4
// Control word flag bits (word bits 0 and 1 set, bit 3 clear)
`define CMDSA_CW_FLAGS 48'hc00000000000
// Reset values
`define CMDSA_RST_SCNT 4'h0
`define CMDSA_RST_ADDR 15'h0000
`endif

// ===== cmdsa_core_asserts.sv
// Port checker for the destination string datapath.
// Assumes a bind to cmdsa_core, one clock and a sync high reset.
`timescale 1ns/1ps
module cmdsa_core_asserts #(
    parameter AW = 15
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_wr,
    input wire i_rd,
    input wire [47:0] o_rdata,
    input wire [AW-1:0] o_mem_addr,
    input wire o_mem_wr,
    input wire o_mem_rd,
    input wire i_mem_ack,
    input wire o_char_mode_flag,
    input wire o_subprogram_level_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ========================================
    // Memory link steps
    sequence mem_req;
        o_mem_wr || o_mem_rd;
    endsequence
    sequence wr_acked;
        o_mem_wr ##[1:9] i_mem_ack;
    endsequence
    mem_excl_a: assert property (!(o_mem_wr && o_mem_rd))
        else $error("memory read and write together");
    wr_pulse_a: assert property (o_mem_wr |=> !o_mem_wr)
        else $error("memory write longer than one cycle");
    rd_pulse_a: assert property (o_mem_rd |=> !o_mem_rd)
        else $error("memory read longer than one cycle");
    one_access_a: assert property (
        mem_req |=> !(o_mem_wr || o_mem_rd) until i_mem_ack)
        else $error("second access before acknowledge");
    next_addr_a: assert property (
        wr_acked ##1 o_mem_rd |-> o_mem_addr == $past(o_mem_addr) + 1'b1)
        else $error("next word not read at address plus one");
    // ========================================
    // Register port and mode flags
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 48'h0)
        else $error("read data outside its cycle");
    entry_flags_a: assert property (
        $rose(o_char_mode_flag) && !$past(i_wr)
        |-> $past(i_mem_ack) && o_subprogram_level_flag)
        else $error("mode entry without ack or sub-program level");
    flag_cause_a: assert property (
        $changed(o_char_mode_flag) || $changed(o_subprogram_level_flag)
        |-> $past(i_wr) || $past(i_mem_ack))
        else $error("mode flag changed without cause");
endmodule // cmdsa_core_asserts

bind cmdsa_core cmdsa_core_asserts #(.AW(AW)) u_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_mem_addr(o_mem_addr), .o_mem_wr(o_mem_wr), .o_mem_rd(o_mem_rd),
    .i_mem_ack(i_mem_ack), .o_char_mode_flag(o_char_mode_flag),
    .o_subprogram_level_flag(o_subprogram_level_flag));

// ===== cmdsa_mem_model.sv
// Core memory model on the far side of the datapath.
// Assumes one access at a time; latency of 1 to 3 cycles from i_lat.
`timescale 1ns/1ps
module cmdsa_mem_model (
    input wire i_clk,
    input wire [14:0] i_addr,
    input wire [47:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [1:0] i_lat,
    output reg [47:0] o_rdata,
    output reg o_ack
);
    reg [47:0] mem [0:255];
    reg [1:0] wait_cnt = 2'h0;
    reg pend = 1'b0;
    reg [7:0] a = 8'h00;
    initial o_ack = 1'b0;
    initial o_rdata = 48'h0;
    // ========================================
    // Access engine; data toggles whenever no answer is given
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_wr || i_rd) begin
            pend <= 1'b1;
            wait_cnt <= i_lat;
            a <= i_addr[7:0];
            if (i_wr) begin
                mem[i_addr[7:0]] <= i_wdata;
            end
        end else if (pend) begin
            if (wait_cnt <= 2'h1) begin
                o_ack <= 1'b1;
                pend <= 1'b0;
                o_rdata <= mem[a];
            end else begin
                wait_cnt <= wait_cnt - 2'h1;
            end
        end
    end
endmodule // cmdsa_mem_model

// ===== cmdsa_core_test.sv
// Self-checking bench for the destination string datapath.
// Assumes cmdsa_regs.vh offsets and the memory model beside the core.
`timescale 1ns/1ps
`include "cmdsa_regs.vh"
module cmdsa_core_test;
    reg i_clk = 1'b0;
    reg i_sys_rst = 1'b1;
    reg [4:0] i_addr = 5'h00;
    reg [47:0] i_wdata = 48'h0;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg [1:0] i_lat = 2'h1;
    wire [47:0] o_rdata, mwd, mrd;
    wire [14:0] maddr;
    wire mwr, mrdq, mack, cm, sp;
    integer error_cnt = 0, cmp_count = 0, cyc = 0, i;
    reg [47:0] mw, v, d, r;
    reg [3:0] ms;
    reg [5:0] mz, my, m;
    reg [2:0] b, c;
    reg [11:0] t;
    cmdsa_core #(.AW(15)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_mem_addr(maddr), .o_mem_wdata(mwd),
        .o_mem_wr(mwr), .o_mem_rd(mrdq), .i_mem_rdata(mrd),
        .i_mem_ack(mack), .o_char_mode_flag(cm),
        .o_subprogram_level_flag(sp));
    cmdsa_mem_model mem (.i_clk(i_clk), .i_addr(maddr), .i_wdata(mwd),
        .i_wr(mwr), .i_rd(mrdq), .i_lat(i_lat), .o_rdata(mrd),
        .o_ack(mack));
    // Clock and hang guard
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            test_done;
        end
    end
    // ========================================
    // Helpers
    function [47:0] rnd48();
        rnd48 = {16'($urandom), $urandom()};
    endfunction
    task chk(input string nm, input [47:0] seen, input [47:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One strobe cycle; read data are taken in the cycle after it
    task acc(input w, input [4:0] a, input [47:0] dat);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= dat;
        i_wr <= w;
        i_rd <= !w;
        i_lat <= 2'd1 + 2'($urandom % 3);
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1 r = o_rdata;
    endtask
    task reg_wr(input [4:0] a, input [47:0] dat);
        acc(1'b1, a, dat);
    endtask
    task rd_chk(input string nm, input [4:0] a, input [47:0] exp);
        acc(1'b0, a, 48'h0);
        chk(nm, r, exp);
    endtask
    // Issue a command, then poll until the busy flag drops
    task run(input [4:0] op);
        integer n;
        reg_wr(`CMDSA_R_CMD, {43'h0, op});
        r = 48'h8;
        for (n = 0; n < 40 && r[3] !== 1'b0; n = n + 1)
            acc(1'b0, `CMDSA_R_FLAGS, 48'h0);
        chk("idle", {47'h0, r[3]}, 48'h0);
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'h089ab8f7));
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd_chk("scnt", `CMDSA_R_SCNT, 0);
        rd_chk("flags", `CMDSA_R_FLAGS, 0);
        rd_chk("unmapped", 5'h1f, 0);
        $display("reset test done");
        mw = rnd48();
        ms = 4'($urandom);
        reg_wr(`CMDSA_R_WORD, mw);
        reg_wr(`CMDSA_R_SCNT, ms);
        repeat (24) begin
            if ($urandom % 2) begin
                run(`CMDSA_C_SHL);
                mw = {mw[44:0], mw[47:45]};
                ms = ms + 4'h1;
            end else begin
                run(`CMDSA_C_SHR);
                mw = {mw[2:0], mw[47:3]};
                ms = ms - 4'h1;
            end
            rd_chk("word", `CMDSA_R_WORD, mw);
            rd_chk("scnt", `CMDSA_R_SCNT, ms);
        end
        $display("rotate test done");
        for (i = 0; i < 8; i = i + 1) begin
            c = 3'(i * 5);
            reg_wr(`CMDSA_R_CSEL, c);
            run(`CMDSA_C_ALIGN);
            while (ms[3:1] != c || ms[0]) begin
                mw = {mw[44:0], mw[47:45]};
                ms = ms + 4'h1;
            end
            rd_chk("scnt", `CMDSA_R_SCNT, ms);
            rd_chk("word", `CMDSA_R_WORD, mw);
            run(`CMDSA_C_FETCH);
            rd_chk("wchr", `CMDSA_R_WCHR, mw[47:42]);
        end
        $display("align test done");
        repeat (4) begin
            mz = 6'($urandom);
            my = 6'($urandom);
            b = 3'($urandom % 6);
            t = 12'($urandom);
            reg_wr(`CMDSA_R_WCHR, mz);
            reg_wr(`CMDSA_R_SCHR, my);
            reg_wr(`CMDSA_R_BSEL, b);
            reg_wr(`CMDSA_R_SYL, t);
            run(`CMDSA_C_PUT);
            mw[5:0] = mz;
            rd_chk("word", `CMDSA_R_WORD, mw);
            run(`CMDSA_C_YTOB);
            mw[5:0] = my;
            rd_chk("word", `CMDSA_R_WORD, mw);
            run(`CMDSA_C_ADD);
            mz = mz + my;
            rd_chk("wchr", `CMDSA_R_WCHR, mz);
            run(`CMDSA_C_BLOAD);
            m = 6'h20 >> b;
            mz = (mz & ~m) | (my & m);
            rd_chk("wchr", `CMDSA_R_WCHR, mz);
            run(`CMDSA_C_BSET);
            rd_chk("wchr", `CMDSA_R_WCHR, mz | m);
            run(`CMDSA_C_BCLR);
            rd_chk("wchr", `CMDSA_R_WCHR, mz & ~m);
            run(`CMDSA_C_LIT);
            rd_chk("wchr", `CMDSA_R_WCHR, t[11:6]);
            run(`CMDSA_C_SYLB);
            mw[5:0] = t[11:6];
            rd_chk("schr", `CMDSA_R_SCHR, t[11:6]);
            rd_chk("word", `CMDSA_R_WORD, mw);
        end
        $display("character test done");
        mw = rnd48();
        v = rnd48();
        mem.mem[11] = v;
        reg_wr(`CMDSA_R_WORD, mw);
        reg_wr(`CMDSA_R_DADDR, 10);
        run(`CMDSA_C_NEXT);
        chk("stored", mem.mem[10], mw);
        rd_chk("daddr", `CMDSA_R_DADDR, 11);
        rd_chk("word", `CMDSA_R_WORD, v);
        rd_chk("scnt", `CMDSA_R_SCNT, 0);
        $display("next word test done");
        d = rnd48() | 48'hc0000000000;
        reg_wr(`CMDSA_R_FLAGS, 0);
        reg_wr(`CMDSA_R_DESC, d);
        run(`CMDSA_C_ENTD);
        rd_chk("flags", `CMDSA_R_FLAGS, 48'h10);
        reg_wr(`CMDSA_R_FLAGS, 4);
        reg_wr(`CMDSA_R_DESC, d & ~48'h40000000000);
        run(`CMDSA_C_ENTD);
        rd_chk("flags", `CMDSA_R_FLAGS, 48'h14);
        reg_wr(`CMDSA_R_FLAGS, 4);
        reg_wr(`CMDSA_R_DESC, d);
        reg_wr(`CMDSA_R_RPTR, 5);
        reg_wr(`CMDSA_R_DADDR, 20);
        reg_wr(`CMDSA_R_TALLY, 7);
        run(`CMDSA_C_ENTD);
        chk("rcw", mem.mem[21], `CMDSA_CW_FLAGS | (48'd5 << 15));
        rd_chk("rptr", `CMDSA_R_RPTR, 21);
        rd_chk("loop", `CMDSA_R_LOOP, 48'd21 << 15);
        rd_chk("paddr", `CMDSA_R_PADDR, d[14:0]);
        rd_chk("tally", `CMDSA_R_TALLY, 0);
        rd_chk("daddr", `CMDSA_R_DADDR, 0);
        rd_chk("flags", `CMDSA_R_FLAGS, 3);
        chk("cm", cm, 1);
        $display("entry test done");
        reg_wr(`CMDSA_R_DADDR, 40);
        run(`CMDSA_C_LCW);
        chk("lcw", mem.mem[22], `CMDSA_CW_FLAGS | (48'd21 << 15));
        rd_chk("daddr", `CMDSA_R_DADDR, 40);
        v = rnd48();
        mem.mem[18] = v;
        reg_wr(`CMDSA_R_SYL, 12'h0c0);
        run(`CMDSA_C_FDA);
        rd_chk("daddr", `CMDSA_R_DADDR, v[14:0]);
        run(`CMDSA_C_FSA);
        rd_chk("saddr", `CMDSA_R_SADDR, v[14:0]);
        reg_wr(`CMDSA_R_FLAGS, 0);
        run(`CMDSA_C_ENTI);
        chk("sp", sp, 1);
        chk("cm", cm, 1);
        $display("stack test done");
        test_done;
    end
endmodule // cmdsa_core_test
